// ### qahp_pkg.sv
`default_nettype none
package qahp_pkg;
    // Channel count and register-select width.
    localparam int QAHP_NUM_CH = 4;
    localparam int QAHP_ADDR_W = 3;
    // Register-select offsets within one channel.
    localparam logic [2:0] QAHP_OFS_IER = 3'h1;
    localparam logic [2:0] QAHP_OFS_MCR = 3'h4;
    localparam logic [2:0] QAHP_OFS_MSR = 3'h6;
    // Field positions.
    localparam int QAHP_MCR_TR_BIT = 0;
    localparam int QAHP_MCR_GATE_BIT = 3;
    localparam int QAHP_MCR_LOOP_BIT = 4;
    localparam int QAHP_MSR_DSR_BIT = 5;
    localparam int QAHP_IER_RDA_BIT = 0;
    localparam int QAHP_IER_THRE_BIT = 1;
    localparam int QAHP_IER_LINE_BIT = 2;
    localparam int QAHP_IER_MODEM_BIT = 3;
    // Reset values.
    localparam logic [7:0] QAHP_MCR_RST = 8'h00;
    localparam logic [7:0] QAHP_IER_RST = 8'h00;
    localparam logic [7:0] QAHP_DOUT_RST = 8'h00;
endpackage
`default_nettype wire

// ### qahp_top.sv
// Function
// [RULE1] Data-set-ready level readable in modem status
// [RULE2] Data-set-ready never affects transmit or receive
// [RULE3] Terminal-ready driven low when its bit set
// [RULE4] Terminal-ready high on reset, loop, cleared bit
// [RULE5] Four interrupt outputs share one force input
// [RULE6] Force low: interrupt gated by gate bit
// [RULE7] Gate clear floats output, set enables it
// [RULE8] Force high: interrupt outputs always enabled
// [RULE9] Interrupt high only for enabled pending sources
// [RULE10] Sources: line error, data/timeout, empty, modem
// [RULE11] Interrupt drops after service or reset
// [RULE12] Read strobe low drives addressed register out
// [RULE13] Write strobe captures data into addressed register
// [RULE14] Reset clears registers, sets outputs defined
// [RULE15] Serial transmit and receive disabled in reset
// [RULE16] Host drives three-bit register-select address
// [RULE17] Strobes act only with channel select low
// [RULE18] Reset puts serial transmit output marking
// [RULE19] Reset asynchronous assert, synchronised release
// [RULE20] Terminal-ready and gate inactive until written
`timescale 1ns/1ps
`default_nettype none
module qahp_top
    import qahp_pkg::*;
#(
    parameter int NUM_CH = QAHP_NUM_CH
)
(
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic clk_en,
    input wire logic [NUM_CH-1:0] channel_select_n,
    input wire logic [QAHP_ADDR_W-1:0] reg_select_addr,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic data_out_en,
    input wire logic interrupt_force_in,
    input wire logic [NUM_CH-1:0] data_set_ready_in,
    input wire logic [NUM_CH-1:0] src_line_err,
    input wire logic [NUM_CH-1:0] src_rx_avail,
    input wire logic [NUM_CH-1:0] src_thr_empty,
    input wire logic [NUM_CH-1:0] src_modem_chg,
    input wire logic [NUM_CH-1:0] serial_rx_in,
    input wire logic [NUM_CH-1:0] serial_tx_core,
    output logic [NUM_CH-1:0] serial_rx_core,
    output logic [NUM_CH-1:0] serial_tx_out,
    output logic [NUM_CH-1:0] terminal_ready_out,
    output logic [NUM_CH-1:0] channel_irq_out,
    output logic [NUM_CH-1:0] channel_irq_oe
);

    // ========================================
    // Reset synchroniser
    // ========================================
    logic rst_s1_r;
    logic rst_s2_r;

    // Reset asserts at once and releases two edges after rst_b rises.
    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_s1_r <= 1'b0; // [RULE19]
            rst_s2_r <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_s2_r <= rst_s1_r;
        end
    end

    wire logic rst_n_i = rst_s2_r;

    // ========================================
    // Channel registers
    // ========================================
    logic [7:0] mcr_r [NUM_CH];
    logic [7:0] mcr_nxt [NUM_CH];
    logic [7:0] ier_r [NUM_CH];
    logic [7:0] ier_nxt [NUM_CH];
    logic [7:0] dout_nxt;
    logic dout_en_nxt;
    logic [NUM_CH-1:0] tr_nxt;
    logic [NUM_CH-1:0] irq_nxt;
    logic [NUM_CH-1:0] oe_nxt;
    logic [NUM_CH-1:0] tx_nxt;
    logic [NUM_CH-1:0] rx_nxt;
    logic [NUM_CH-1:0] sel_c;

    // Decode, register writes, read mux and all pin next values.
    always_comb
    begin
        dout_nxt = QAHP_DOUT_RST;
        dout_en_nxt = 1'b0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            sel_c[i] = !channel_select_n[i]; // [RULE17]
            mcr_nxt[i] = mcr_r[i];
            ier_nxt[i] = ier_r[i];
            if (sel_c[i] && !write_strobe_n) // [RULE13] [RULE16]
            begin
                if (reg_select_addr == QAHP_OFS_MCR)
                    mcr_nxt[i] = data_in; // [RULE20]
                else if (reg_select_addr == QAHP_OFS_IER)
                    ier_nxt[i] = data_in;
            end
            if (sel_c[i] && !read_strobe_n) // [RULE12]
            begin
                dout_en_nxt = 1'b1;
                unique case (reg_select_addr)
                    QAHP_OFS_MCR: dout_nxt = mcr_r[i];
                    QAHP_OFS_IER: dout_nxt = ier_r[i];
                    QAHP_OFS_MSR:
                    begin
                        // Clear first, so a lower channel's word never leaks into this read.
                        dout_nxt = QAHP_DOUT_RST;
                        dout_nxt[QAHP_MSR_DSR_BIT] = !data_set_ready_in[i]; // [RULE1]
                    end
                    default: dout_nxt = QAHP_DOUT_RST;
                endcase
            end
            // Terminal-ready is active low; loop mode forces it high.
            tr_nxt[i] = !(mcr_r[i][QAHP_MCR_TR_BIT] && !mcr_r[i][QAHP_MCR_LOOP_BIT]); // [RULE3] [RULE4]
            // Pending request needs an enabled source; it falls when the source clears.
            irq_nxt[i] = (src_line_err[i] && ier_r[i][QAHP_IER_LINE_BIT])
                || (src_rx_avail[i] && ier_r[i][QAHP_IER_RDA_BIT])
                || (src_thr_empty[i] && ier_r[i][QAHP_IER_THRE_BIT])
                || (src_modem_chg[i] && ier_r[i][QAHP_IER_MODEM_BIT]); // [RULE9] [RULE10] [RULE11]
            // One shared force input governs every driver enable.
            oe_nxt[i] = interrupt_force_in || mcr_r[i][QAHP_MCR_GATE_BIT]; // [RULE5] [RULE6] [RULE7] [RULE8]
            // Data-set-ready does not enter the serial path at all.
            tx_nxt[i] = serial_tx_core[i]; // [RULE2]
            rx_nxt[i] = serial_rx_in[i];
        end
    end

    // Registers; reset clears control and parks the pins in safe states.
    always_ff @(posedge core_clk or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                mcr_r[i] <= QAHP_MCR_RST; // [RULE14]
                ier_r[i] <= QAHP_IER_RST;
            end
            data_out <= QAHP_DOUT_RST;
            data_out_en <= 1'b0;
            terminal_ready_out <= '1; // [RULE4]
            channel_irq_out <= '0; // [RULE11]
            channel_irq_oe <= '0;
            serial_tx_out <= '1; // [RULE15] [RULE18]
            serial_rx_core <= '1; // [RULE15]
        end
        else if (clk_en)
        begin
            for (int i = 0; i < NUM_CH; i++)
            begin
                mcr_r[i] <= mcr_nxt[i];
                ier_r[i] <= ier_nxt[i];
            end
            data_out <= dout_nxt;
            data_out_en <= dout_en_nxt;
            terminal_ready_out <= tr_nxt;
            channel_irq_out <= irq_nxt;
            channel_irq_oe <= oe_nxt;
            serial_tx_out <= tx_nxt;
            serial_rx_core <= rx_nxt;
        end
    end

    // ========================================
    // Assertions
    // ========================================
    sequence s_force_high;
        interrupt_force_in && clk_en;
    endsequence

    a_force_enables_irq: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE8]
        s_force_high |=> channel_irq_oe == '1)
        else $error("Force input did not enable all interrupt drivers.");

    a_read_drives_bus: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE12]
        (clk_en && !read_strobe_n && (channel_select_n != '1)) |=> data_out_en)
        else $error("Read strobe did not drive the data bus.");

    a_dsr_readback: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE1]
        (clk_en && !channel_select_n[0] && (channel_select_n[NUM_CH-1:1] == '1) && !read_strobe_n
        && reg_select_addr == QAHP_OFS_MSR) |=> data_out[QAHP_MSR_DSR_BIT] == !$past(data_set_ready_in[0]))
        else $error("Data-set-ready level not reflected in status read.");

    a_tx_follows_core: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE2]
        clk_en |=> serial_tx_out == $past(serial_tx_core))
        else $error("Transmit pin did not follow the core transmit bit.");

    // Per-channel checks, so that whichever channel a test drives is watched.
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_chan_chk
        a_gate_floats_irq: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE7]
            (clk_en && !interrupt_force_in && !mcr_r[g][QAHP_MCR_GATE_BIT]) |=> !channel_irq_oe[g])
            else $error("Interrupt driven while gate bit clear.");

        a_gate_enables_irq: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE6]
            (clk_en && mcr_r[g][QAHP_MCR_GATE_BIT]) |=> channel_irq_oe[g])
            else $error("Interrupt driver off while gate bit set.");

        a_tr_follows_bit: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE3]
            (clk_en && mcr_r[g][QAHP_MCR_TR_BIT] && !mcr_r[g][QAHP_MCR_LOOP_BIT]) |=> !terminal_ready_out[g])
            else $error("Terminal-ready not active with bit set.");

        a_tr_loop_idle: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE4]
            (clk_en && mcr_r[g][QAHP_MCR_LOOP_BIT]) |=> terminal_ready_out[g])
            else $error("Terminal-ready active in loop mode.");

        a_irq_needs_enable: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE9]
            (clk_en && ier_r[g] == 8'h00) |=> !channel_irq_out[g])
            else $error("Interrupt raised with no enabled source.");

        a_irq_thre_source: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE10]
            (clk_en && src_thr_empty[g] && ier_r[g][QAHP_IER_THRE_BIT]) |=> channel_irq_out[g])
            else $error("Enabled transmit-empty source did not raise interrupt.");

        a_write_needs_select: assert property (@(posedge core_clk) disable iff (!rst_n_i) // [RULE17]
            (clk_en && channel_select_n[g]) |=> $stable(mcr_r[g]))
            else $error("Unselected channel register changed.");
    end

endmodule
`default_nettype wire

// ### qahp_modem.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Modem ready lines and the shared interrupt wires.
module qahp_modem
(
    input wire logic [3:0] dsr_level,
    input wire logic [3:0] irq_out,
    input wire logic [3:0] irq_oe,
    output logic [3:0] data_set_ready_in,
    output wire [3:0] irq_pin
);
    // The data set shows the level it is told to; a released driver floats.
    assign data_set_ready_in = dsr_level;
    for (genvar i = 0; i < 4; i++)
    begin : g_pin
        assign irq_pin[i] = irq_oe[i] ? irq_out[i] : 1'bz;
    end
endmodule
`default_nettype wire

// ### quad_async_host_pins_irq_gating_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====
// Self-checking bench for the host pin block.
module quad_async_host_pins_irq_gating_tb_top;
    import qahp_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic clk_en = 1'b1;
    logic [3:0] tx = 4'hA;
    logic rd_n = 1'b1;
    logic wr_n = 1'b1;
    logic force_in = 1'b0;
    logic [3:0] sel_n = 4'hF;
    logic [3:0] dsr = 4'hF;
    logic [3:0] rx = 4'hF;
    logic [15:0] src = 16'h0000;
    logic [2:0] addr = 3'h0;
    logic [7:0] din = 8'h00;
    logic [7:0] dout;
    logic dout_en;
    logic [3:0] dsr_pin, rxc, txo, tro, irq, oe;
    wire [3:0] irq_pin;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    // A 25 ns clock.
    always #12.5 core_clk = ~core_clk;
    qahp_top i_dut (.core_clk(core_clk), .rst_b(rst_b), .clk_en(clk_en), .channel_select_n(sel_n),
        .reg_select_addr(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .data_in(din),
        .data_out(dout), .data_out_en(dout_en), .interrupt_force_in(force_in), .data_set_ready_in(dsr_pin),
        .src_rx_avail(src[3:0]), .src_thr_empty(src[7:4]), .src_line_err(src[11:8]),
        .src_modem_chg(src[15:12]), .serial_rx_in(rx), .serial_tx_core(tx), .serial_rx_core(rxc),
        .serial_tx_out(txo), .terminal_ready_out(tro), .channel_irq_out(irq), .channel_irq_oe(oe));
    qahp_modem i_modem (.dsr_level(dsr), .irq_out(irq), .irq_oe(oe), .data_set_ready_in(dsr_pin),
        .irq_pin(irq_pin));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // A channel number of 4 selects no channel at all.
    task automatic wr(input int ch, input logic [2:0] a, input logic [7:0] d);
        @(negedge core_clk);
        sel_n = ~(4'h1 << ch);
        addr = a;
        din = d;
        wr_n = 1'b0;
        @(negedge core_clk);
        wr_n = 1'b1;
        sel_n = 4'hF;
        @(negedge core_clk);
    endtask
    task automatic rd(input int ch, input logic [2:0] a, input logic [7:0] exp);
        @(negedge core_clk);
        sel_n = ~(4'h1 << ch);
        addr = a;
        rd_n = 1'b0;
        repeat (2) @(negedge core_clk);
        chk(dout, exp);
        chk({7'h00, dout_en}, {7'h00, ch < 4});
        rd_n = 1'b1;
        sel_n = 4'hF;
    endtask
    task automatic t_reset();
        chk({4'h0, tro}, 8'h0F);
        chk({txo, rxc}, 8'hFF);
        chk({oe, irq}, 8'h00);
        chk({7'h00, dout_en}, 8'h00);
    endtask
    // A write while the clock enable is low must leave the channel untouched.
    task automatic t_dtr();
        clk_en = 1'b0;
        wr(2, QAHP_OFS_MCR, 8'h01);
        chk({4'h0, tro}, 8'h0F);
        clk_en = 1'b1;
        wr(2, QAHP_OFS_MCR, 8'h01);
        chk({4'h0, tro}, 8'h0B);
        rd(2, QAHP_OFS_MCR, 8'h01);
        wr(2, QAHP_OFS_MCR, 8'h11);
        chk({4'h0, tro}, 8'h0F);
        wr(2, QAHP_OFS_MCR, 8'h01);
        wr(2, QAHP_OFS_MCR, 8'h00);
        chk({4'h0, tro}, 8'h0F);
        wr(4, QAHP_OFS_MCR, 8'h01);
        chk({4'h0, tro}, 8'h0F);
    endtask
    task automatic t_dsr();
        dsr = 4'hD;
        rx = 4'h6;
        tx = 4'h5;
        rd(1, QAHP_OFS_MSR, 8'h20);
        rd(0, QAHP_OFS_MSR, 8'h00);
        rd(1, 3'h7, 8'h00);
        rd(4, QAHP_OFS_MSR, 8'h00);
        chk({txo, rxc}, 8'h56);
    endtask
    // Each enable bit is tried with every other source pending.
    task automatic t_irq();
        wr(3, QAHP_OFS_MCR, 8'h08);
        chk({4'h0, oe}, 8'h08);
        for (int b = 0; b < 4; b++)
        begin
            wr(3, QAHP_OFS_IER, 8'h01 << b);
            rd(3, QAHP_OFS_IER, 8'h01 << b);
            src = ~(16'h000F << (4 * b));
            @(negedge core_clk);
            chk({4'h0, irq}, 8'h00);
            src = 16'hFFFF;
            @(negedge core_clk);
            chk({4'h0, irq}, 8'h08);
            src = 16'h0000;
            @(negedge core_clk);
            chk({4'h0, irq}, 8'h00);
        end
        wr(3, QAHP_OFS_MCR, 8'h00);
        chk({irq_pin, oe}, {4'hz, 4'h0});
        force_in = 1'b1;
        @(negedge core_clk);
        chk({4'h0, oe}, 8'h0F);
        force_in = 1'b0;
        wr(3, QAHP_OFS_MCR, 8'h09);
        src = 16'hFFFF;
        @(negedge core_clk);
        chk({tro, irq}, 8'h78);
        rst_b = 1'b0;
        #1;
        t_reset();
    endtask
    // Main sequence, with a second reset in mid-run.
    initial
    begin
        repeat (3) @(negedge core_clk);
        t_reset();
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({oe, tro}, 8'h0F);
        t_dtr();
        t_dsr();
        t_irq();
        @(negedge core_clk);
        rst_b = 1'b1;
        repeat (4) @(negedge core_clk);
        chk({oe, tro}, 8'h0F);
        summarize();
    end
    // Cuts a hang short.
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            n_fail++;
            summarize();
        end
    end
endmodule
`default_nettype wire
